// [design/rlc_cmd_core.sv]
// Functional notes
// - Lock command in remote enters lockout
// - Lockout blocks every front-panel control
// - Only return-to-local or bus REN false leaves lockout
// - Lock accepted on serial only, sequential
// - Serial lock equals bus lockout message
// - Loop query answers ON or OFF
// - Loop disable turns supply off, silent
// - Loop enable turns supply on, silent
// - Completion command sets status bit zero
// - Completion query replies 1 when idle
// - Operate command connects output terminals
// - Operate is overlapped, both interfaces
// - Operate shows indicator on display
// - Operate query replies 1 or 0
// - Serial return-to-local clears remote and lockout
//
// Purpose: Remote command core for lockout, loop supply, completion and operate
// Assumes: Commands pre-decoded; one command strobe per cycle at most
// Notes:   Reply held until reply_ack_i
`timescale 1ns/100ps
module rlc_cmd_core (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire logic                  cmd_valid_i,
  input  rlc_pkg::rlc_cmd_type       cmd_i,
  input  wire logic                  cmd_serial_i,
  output logic                       cmd_ready_o,
  output rlc_pkg::rlc_reply_type     reply_o,
  output logic                       reply_valid_o,
  input  wire logic                  reply_ack_i,
  input  wire logic                  bus_llo_i,
  input  wire logic                  bus_ren_false_i,
  input  wire logic                  fp_local_key_i,
  input  wire logic                  fp_operate_key_i,
  input  wire logic                  fp_standby_key_i,
  input  wire logic                  fp_other_key_i,
  input  wire logic                  op_done_i,
  input  wire logic                  esr_clear_i,
  output logic                       remote_o,
  output logic                       lockout_o,
  output logic                       fp_key_o,
  output logic                       loop_power_o,
  output logic                       output_connect_o,
  output logic                       operate_ind_o,
  output logic [7:0]                 esr_o
);
  import rlc_pkg::*;

  typedef struct packed {
    rlc_state_type st;
    logic          remote;
    logic          lockout;
    logic          loop;
    logic          conn;
    logic [7:0]    esr;
    rlc_reply_type reply;
    logic          rvalid;
    logic          fp_key;
  } rlc_core_state_type;

  rlc_core_state_type r;
  rlc_core_state_type next_r;
  logic               idle;
  logic               take;
  logic               conn_start;

  // ----------------------------------------------------------------
  // Pending tracker
  // ----------------------------------------------------------------
  rlc_pend_tracker u_pend (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .start_i (conn_start),
    .done_i  (op_done_i),
    .idle_o  (idle)
  );

  // All commands wait for idle state and no held reply; only OPC and OPC query wait for tracker idle
  assign cmd_ready_o = (r.st == RLC_ST_IDLE) && !r.rvalid;
  assign take        = cmd_valid_i && cmd_ready_o;
  assign conn_start  = take && (cmd_i == RLC_CMD_OPERATE);

  // ----------------------------------------------------------------
  // Command interpreter
  // ----------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.fp_key = 1'b0;
    if (r.rvalid && reply_ack_i) begin
      next_r.rvalid = 1'b0;
    end
    if (esr_clear_i) begin
      next_r.esr = RLC_ESR_RESET;
    end
    if (!r.lockout) begin
      next_r.fp_key = fp_other_key_i;
      if (fp_local_key_i) begin
        next_r.remote = 1'b0;
      end
      if (fp_operate_key_i) begin
        next_r.conn = 1'b1;
      end else if (fp_standby_key_i) begin
        next_r.conn = 1'b0;
      end
    end
    if (bus_llo_i && r.remote) begin
      next_r.lockout = 1'b1;
    end
    if (bus_ren_false_i) begin
      next_r.remote  = 1'b0;
      next_r.lockout = 1'b0;
    end
    case (r.st)
      RLC_ST_IDLE: begin
        if (take) begin
          case (cmd_i)
            RLC_CMD_REMOTE: begin
              next_r.remote = 1'b1;
            end
            RLC_CMD_LOCKOUT: begin
              if (cmd_serial_i && r.remote) begin
                next_r.lockout = 1'b1;
              end
            end
            RLC_CMD_LOCAL: begin
              if (cmd_serial_i) begin
                next_r.remote  = 1'b0;
                next_r.lockout = 1'b0;
              end
            end
            RLC_CMD_LOOP_Q: begin
              next_r.reply  = r.loop ? RLC_RPL_ON : RLC_RPL_OFF;
              next_r.rvalid = 1'b1;
            end
            RLC_CMD_LOOP_OFF: begin
              next_r.loop = 1'b0;
            end
            RLC_CMD_LOOP_ON: begin
              next_r.loop = 1'b1;
            end
            RLC_CMD_OPC: begin
              next_r.st = RLC_ST_OPC_WAIT;
            end
            RLC_CMD_OPC_Q: begin
              next_r.st = RLC_ST_OPCQ_WAIT;
            end
            RLC_CMD_OPERATE: begin
              next_r.conn = 1'b1;
            end
            RLC_CMD_CONN_Q: begin
              next_r.reply  = r.conn ? RLC_RPL_ONE : RLC_RPL_ZERO;
              next_r.rvalid = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      RLC_ST_OPC_WAIT: begin
        if (idle) begin
          next_r.esr[RLC_ESR_OPC_BIT] = 1'b1;
          next_r.st                   = RLC_ST_IDLE;
        end
      end
      RLC_ST_OPCQ_WAIT: begin
        if (idle) begin
          next_r.reply  = RLC_RPL_ONE;
          next_r.rvalid = 1'b1;
          next_r.st     = RLC_ST_IDLE;
        end
      end
      default: begin
        next_r.st = RLC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r        <= '0;
      r.st     <= RLC_ST_IDLE;
      r.loop   <= RLC_LOOP_RESET;
      r.conn   <= RLC_CONN_RESET;
      r.esr    <= RLC_ESR_RESET;
      r.reply  <= RLC_RPL_NONE;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reply_o          = r.reply;
  assign reply_valid_o    = r.rvalid;
  assign remote_o         = r.remote;
  assign lockout_o        = r.lockout;
  assign fp_key_o         = r.fp_key;
  assign loop_power_o     = r.loop;
  assign output_connect_o = r.conn;
  assign operate_ind_o    = r.conn;
  assign esr_o            = r.esr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_lock_enter: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && take && cmd_i == RLC_CMD_LOCKOUT && cmd_serial_i && remote_o |=> lockout_o)
    else $error("lockout not entered");
  a_lock_keys: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lockout_o && ce_i && fp_local_key_i && !bus_ren_false_i && !(take && cmd_i == RLC_CMD_LOCAL)
    |=> remote_o == $past(remote_o))
    else $error("local key acted in lockout");
  a_lock_stays: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lockout_o && ce_i && !bus_ren_false_i && !(take && cmd_i == RLC_CMD_LOCAL && cmd_serial_i) |=> lockout_o)
    else $error("lockout left without local");
  a_lock_parallel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !lockout_o && take && cmd_i == RLC_CMD_LOCKOUT && !cmd_serial_i && !bus_llo_i |=> !lockout_o)
    else $error("lock taken on parallel bus");
  a_loop_query: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && take && cmd_i == RLC_CMD_LOOP_Q
    |=> reply_valid_o && reply_o == ($past(loop_power_o) ? RLC_RPL_ON : RLC_RPL_OFF))
    else $error("loop query wrong");
  a_loop_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && take && cmd_i == RLC_CMD_LOOP_OFF |=> !loop_power_o && !reply_valid_o)
    else $error("loop not off");
  a_loop_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && take && cmd_i == RLC_CMD_LOOP_ON |=> loop_power_o && !reply_valid_o)
    else $error("loop not on");
  a_opc_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && r.st == RLC_ST_OPC_WAIT && idle && !esr_clear_i |=> esr_o[RLC_ESR_OPC_BIT])
    else $error("opc bit not set");
  a_opcq_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    r.st == RLC_ST_OPCQ_WAIT && !idle |=> !reply_valid_o)
    else $error("opc query answered early");
  a_conn_ind: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && conn_start |=> output_connect_o && operate_ind_o && cmd_ready_o)
    else $error("operate not applied");
  a_conn_query: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && take && cmd_i == RLC_CMD_CONN_Q
    |=> reply_o == ($past(output_connect_o) ? RLC_RPL_ONE : RLC_RPL_ZERO))
    else $error("operate query wrong");

endmodule

// [design/rlc_pend_tracker.sv]
// Purpose: Counts overlapped operations still in progress
// Assumes: Start and done strobes are one cycle each
// Notes:   Saturates at both ends
`timescale 1ns/100ps
module rlc_pend_tracker #(
  parameter int W = rlc_pkg::RLC_PEND_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         start_i,
  input  wire logic         done_i,
  output logic              idle_o
);
  import rlc_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } rlc_pend_state_type;

  rlc_pend_state_type r;
  rlc_pend_state_type next_r;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (start_i && !done_i && r.cnt != {W{1'b1}}) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (done_i && !start_i && r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign idle_o = (r.cnt == '0);

  a_idle_means_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && start_i && !done_i |=> !idle_o) else $error("tracker idle after start");

endmodule

// [shared/rlc_pkg.sv]
// Purpose: Shared constants and types for the remote lockout/loop/operate command block
// Assumes: Commands arrive already decoded as one-cycle strobes
// Notes:   Reply codes are single characters or short words
package rlc_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RLC_CMD_NONE      = 4'h0,
    RLC_CMD_LOCKOUT   = 4'h1,
    RLC_CMD_LOCAL     = 4'h2,
    RLC_CMD_LOOP_Q    = 4'h3,
    RLC_CMD_LOOP_OFF  = 4'h4,
    RLC_CMD_LOOP_ON   = 4'h5,
    RLC_CMD_OPC       = 4'h6,
    RLC_CMD_OPC_Q     = 4'h7,
    RLC_CMD_OPERATE   = 4'h8,
    RLC_CMD_CONN_Q    = 4'h9,
    RLC_CMD_REMOTE    = 4'hA
  } rlc_cmd_type;

  // ----------------------------------------------------------------
  // Reply codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RLC_RPL_NONE = 3'h0,
    RLC_RPL_ON   = 3'h1,
    RLC_RPL_OFF  = 3'h2,
    RLC_RPL_ONE  = 3'h3,
    RLC_RPL_ZERO = 3'h4
  } rlc_reply_type;

  // ----------------------------------------------------------------
  // Interpreter states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RLC_ST_IDLE     = 2'b00,
    RLC_ST_OPC_WAIT = 2'b01,
    RLC_ST_OPCQ_WAIT = 2'b10
  } rlc_state_type;

  localparam int          RLC_PEND_W      = 4;
  localparam logic [7:0]  RLC_ESR_RESET   = 8'h00;
  localparam int          RLC_ESR_OPC_BIT = 0;
  localparam logic        RLC_LOOP_RESET  = 1'b0;
  localparam logic        RLC_CONN_RESET  = 1'b0;

endpackage

// [verification/remote_lockout_loop_power_operate_cmds_bench.sv]
// Purpose: Scenario bench for the command core
// Assumes: Clock enable held high
// Notes:   Pulse tasks return mid-cycle for checking
`timescale 1ns/100ps
module remote_lockout_loop_power_operate_cmds_bench;
  import rlc_pkg::*;
  localparam int LLO     = 0;
  localparam int REN_F   = 1;
  localparam int K_LOC   = 2;
  localparam int K_OP    = 3;
  localparam int K_SB    = 4;
  localparam int K_OTH   = 5;
  localparam int OP_DONE = 6;
  localparam int ESR_CLR = 7;
  logic          clk_i, rst_n_i, valid, serial, ready, rvalid, ack;
  logic [7:0]    pin;
  logic          remote, lockout, fp_key, loop_pw, out_conn, conn_ind;
  logic [7:0]    esr;
  rlc_cmd_type   cmd;
  rlc_reply_type reply, rp;
  int            miscompares, tests_run, cyc;

  rlc_cmd_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .cmd_valid_i(valid), .cmd_i(cmd), .cmd_serial_i(serial), .cmd_ready_o(ready),
    .reply_o(reply), .reply_valid_o(rvalid), .reply_ack_i(ack), .bus_llo_i(pin[LLO]),
    .bus_ren_false_i(pin[REN_F]), .fp_local_key_i(pin[K_LOC]), .fp_operate_key_i(pin[K_OP]),
    .fp_standby_key_i(pin[K_SB]), .fp_other_key_i(pin[K_OTH]), .op_done_i(pin[OP_DONE]),
    .esr_clear_i(pin[ESR_CLR]), .remote_o(remote), .lockout_o(lockout), .fp_key_o(fp_key),
    .loop_power_o(loop_pw), .output_connect_o(out_conn), .operate_ind_o(conn_ind),
    .esr_o(esr));
  rlc_host_model host_u (.clk_i(clk_i), .ready_i(ready), .rvalid_i(rvalid),
    .reply_i(reply), .valid_o(valid), .cmd_o(cmd), .serial_o(serial), .ack_o(ack));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One-cycle pulse on a pin selected by index
  task automatic pulse(input int k);
    @(posedge clk_i);
    pin[k] <= 1'b1;
    @(posedge clk_i);
    pin[k] <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic results;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_lock;
    host_u.send(RLC_CMD_REMOTE, 1'b1);
    pulse(K_OTH);
    check(fp_key, 1'b1);
    host_u.send(RLC_CMD_LOCKOUT, 1'b0);
    idle(3);
    check(lockout, 1'b0);
    host_u.send(RLC_CMD_LOCKOUT, 1'b1);
    idle(3);
    check(lockout, 1'b1);
    pulse(K_OTH);
    check(fp_key, 1'b0);
    pulse(K_LOC);
    pulse(K_OP);
    idle(2);
    check({remote, lockout, out_conn}, 3'b110);
    host_u.send(RLC_CMD_LOOP_ON, 1'b0);
    idle(3);
    check(loop_pw, 1'b1);
    host_u.send(RLC_CMD_LOCAL, 1'b0);
    idle(3);
    check(lockout, 1'b1);
    host_u.send(RLC_CMD_LOCAL, 1'b1);
    idle(3);
    check({remote, lockout}, 2'b00);
    $display("t_lock done");
  endtask

  task automatic t_llo;
    pulse(LLO);
    idle(2);
    check(lockout, 1'b0);
    host_u.send(RLC_CMD_REMOTE, 1'b1);
    pulse(LLO);
    idle(2);
    check(lockout, 1'b1);
    pulse(REN_F);
    idle(2);
    check({remote, lockout}, 2'b00);
    $display("t_llo done");
  endtask

  task automatic t_loop;
    host_u.send(RLC_CMD_LOOP_OFF, 1'b0);
    host_u.get(rp, 4);
    check(rp, RLC_RPL_NONE);
    check(loop_pw, 1'b0);
    host_u.send(RLC_CMD_LOOP_Q, 1'b1);
    host_u.get(rp, 8);
    check(rp, RLC_RPL_OFF);
    host_u.send(RLC_CMD_LOOP_ON, 1'b1);
    host_u.get(rp, 4);
    check(rp, RLC_RPL_NONE);
    host_u.send(RLC_CMD_LOOP_Q, 1'b0);
    host_u.get(rp, 8);
    check(rp, RLC_RPL_ON);
    $display("t_loop done");
  endtask

  task automatic t_conn;
    host_u.send(RLC_CMD_CONN_Q, 1'b0);
    host_u.get(rp, 8);
    check(rp, RLC_RPL_ZERO);
    host_u.send(RLC_CMD_OPERATE, 1'b0);
    idle(1);
    check(ready, 1'b1);
    idle(3);
    check(out_conn, 1'b1);
    check(conn_ind, 1'b1);
    host_u.send(RLC_CMD_CONN_Q, 1'b1);
    host_u.get(rp, 8);
    check(rp, RLC_RPL_ONE);
    pulse(OP_DONE);
    pulse(K_SB);
    idle(2);
    check({out_conn, conn_ind}, 2'b00);
    host_u.send(RLC_CMD_CONN_Q, 1'b1);
    host_u.get(rp, 8);
    check(rp, RLC_RPL_ZERO);
    $display("t_conn done");
  endtask

  task automatic t_opc;
    host_u.send(RLC_CMD_OPERATE, 1'b1);
    host_u.send(RLC_CMD_OPC, 1'b0);
    idle(4);
    check(esr[0], 1'b0);
    pulse(OP_DONE);
    idle(3);
    check(esr[0], 1'b1);
    pulse(ESR_CLR);
    idle(1);
    check(esr, 8'h00);
    host_u.send(RLC_CMD_OPERATE, 1'b0);
    host_u.send(RLC_CMD_OPC_Q, 1'b1);
    host_u.get(rp, 4);
    check(rp, RLC_RPL_NONE);
    pulse(OP_DONE);
    host_u.get(rp, 8);
    check(rp, RLC_RPL_ONE);
    $display("t_opc done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results;
    end
  end
  initial begin
    {rst_n_i, pin} = '0;
    miscompares = 0;
    tests_run   = 0;
    cyc         = 0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_lock;
    t_llo;
    t_loop;
    t_conn;
    t_opc;
    results;
  end
endmodule

// [verification/rlc_host_model.sv]
// Purpose: Remote host driving decoded commands
// Assumes: Ready sampled mid-cycle, before edge
// Notes:   Released lines are inverted
`timescale 1ns/100ps
module rlc_host_model (
  input  wire logic             clk_i,
  input  wire logic             ready_i,
  input  wire logic             rvalid_i,
  input  rlc_pkg::rlc_reply_type reply_i,
  output logic                  valid_o,
  output rlc_pkg::rlc_cmd_type  cmd_o,
  output logic                  serial_o,
  output logic                  ack_o
);
  import rlc_pkg::*;

  initial begin
    valid_o  = 1'b0;
    cmd_o    = RLC_CMD_NONE;
    serial_o = 1'b0;
    ack_o    = 1'b0;
  end

  task automatic send(input rlc_cmd_type c, input logic s);
    logic r;
    @(posedge clk_i);
    valid_o  <= 1'b1;
    cmd_o    <= c;
    serial_o <= s;
    do begin
      @(negedge clk_i);
      r = ready_i;
      @(posedge clk_i);
    end while (r !== 1'b1);
    valid_o  <= 1'b0;
    cmd_o    <= rlc_cmd_type'(~c);
    serial_o <= ~s;
  endtask

  task automatic get(output rlc_reply_type rp, input int lim);
    int n;
    n  = 0;
    rp = RLC_RPL_NONE;
    while (n < lim) begin
      @(negedge clk_i);
      n++;
      if (rvalid_i === 1'b1) begin
        rp = reply_i;
        @(posedge clk_i);
        ack_o <= 1'b1;
        @(posedge clk_i);
        ack_o <= 1'b0;
        n = lim;
      end
    end
  endtask
endmodule
